/* hw/mux_pkg.sv */
// Shared constants and types for the four-line serial multiplexer
`default_nettype none
package mux_pkg;
    // Register select addresses (byte addresses on the device bus)
    localparam logic [2:0] ADDR_CONTROL_STATUS = 3'h0;
    localparam logic [2:0] ADDR_RECEIVE_BUFFER = 3'h2;
    localparam logic [2:0] ADDR_LINE_PARAMETERS = 3'h2;
    localparam logic [2:0] ADDR_TRANSMITTER_CONTROL = 3'h4;
    localparam logic [2:0] ADDR_MODEM_STATUS = 3'h6;
    localparam logic [2:0] ADDR_TRANSMIT_DATA = 3'h6;

    // control_status fields
    localparam int CS_TRANSMITTER_READY_FLAG = 15;
    localparam int CS_TIE = 14;
    localparam int CS_SA = 13;
    localparam int CS_SAE = 12;
    localparam int CS_TLINE_LO = 8;
    localparam int CS_RDONE = 7;
    localparam int CS_RIE = 6;
    localparam int CS_MSE = 5;
    localparam int CS_CLR = 4;
    localparam int CS_MAINT = 3;
    // receive_buffer fields
    localparam int RB_VALID = 15;
    localparam int RB_OVRN = 14;
    localparam int RB_FRAM = 13;
    localparam int RB_PAR = 12;
    localparam int RB_LINE_LO = 8;
    // line_parameters fields
    localparam int LP_RX_EN = 12;
    localparam int LP_SPEED_LO = 8;
    localparam int LP_ODD = 7;
    localparam int LP_PAR_EN = 6;
    localparam int LP_STOP = 5;
    localparam int LP_LEN_LO = 3;
    localparam int LP_LINE_LO = 0;
    // transmitter_control, modem_status, transmit_data fields
    localparam int TC_EN_LO = 0;
    localparam int TC_DTR_LO = 8;
    localparam int MS_RING_LO = 0;
    localparam int MS_CARR_LO = 8;
    localparam int TD_BRK_LO = 8;

    localparam int VEC_SRC_BIT = 2;
    localparam logic [4:0] ALARM_COUNT = 5'h10;
    localparam logic [2:0] SCAN_LAST = 3'h7;
    localparam int SILO_DEPTH = 64;

    // Strobe positions inside pins_t.strobe
    localparam int ST_RD = 0;
    localparam int ST_WLO = 1;
    localparam int ST_WHI = 2;
    localparam int ST_IAK = 3;
    localparam int ST_INIT = 4;

    typedef struct packed {
        logic fram;
        logic ovrn;
        logic par;
        logic [7:0] data;
    } uart_rx_t;

    typedef struct packed {
        logic fram;
        logic ovrn;
        logic par;
        logic [1:0] line;
        logic [7:0] data;
    } silo_entry_t;

    typedef struct packed {
        logic receive_line_enable;
        logic [3:0] speed;
        logic odd;
        logic par_en;
        logic stop;
        logic [1:0] len;
    } line_param_t;

    typedef struct packed {
        logic [2:0] addr;
        logic [15:0] data;
        logic [4:0] strobe;
        logic [3:0] da;
        logic [3:0] tbmt;
        logic [7:0] modem;
        uart_rx_t [3:0] rx;
    } pins_t;

    function automatic logic [2:0] reg_addr(input logic [2:0] a);
        return {a[2:1], 1'b0};
    endfunction
endpackage
`default_nettype wire

/* hw/receive_silo.sv */
// Fall-through receive silo holding received characters
`timescale 1ns/100ps
`default_nettype none
module receive_silo #(
    parameter int DEPTH = mux_pkg::SILO_DEPTH,
    parameter int AW = $clog2(DEPTH)
) (
    input wire logic mclk_in,
    input wire logic rst_n_in,
    input wire logic flush_in,
    input wire logic load_in,
    input wire mux_pkg::silo_entry_t entry_in,
    input wire logic unload_in,
    output logic in_ready_out,
    output logic out_ready_out,
    output mux_pkg::silo_entry_t entry_out
);
    typedef struct packed {
        logic [AW:0] count;
        logic [AW-1:0] rd;
        logic [AW-1:0] wr;
    } silo_state_t;

    silo_state_t s;
    silo_state_t next_s;
    mux_pkg::silo_entry_t mem [DEPTH];
    logic do_load;
    logic do_unload;

    assign in_ready_out = s.count != (AW + 1)'(DEPTH);
    assign out_ready_out = s.count != '0;
    assign do_load = load_in & in_ready_out;
    assign do_unload = unload_in & out_ready_out;
    // Oldest entry is visible at once, no ripple through stages
    assign entry_out = mem[s.rd];

    // DEPTH must be a power of two: pointers wrap by overflow
    always_comb
    begin
        next_s = s;
        if (do_load)
            next_s.wr = s.wr + 1'b1;
        if (do_unload)
            next_s.rd = s.rd + 1'b1;
        next_s.count = s.count + (AW + 1)'(do_load) - (AW + 1)'(do_unload);
        if (flush_in)
            next_s = '0;
    end

    always_ff @(posedge mclk_in)
    begin
        if (!rst_n_in)
            s <= '0;
        else
            s <= next_s;
    end

    always_ff @(posedge mclk_in)
    begin
        if (do_load)
            mem[s.wr] <= entry_in;
    end

    a_silo_count_moves: assert property (@(posedge mclk_in)
        disable iff (!rst_n_in) (do_load && !do_unload && !flush_in)
        |=> s.count == $past(s.count) + 1'b1)
        else $error("silo count did not follow a load");
endmodule
`default_nettype wire

/* hw/four_line_async_mux_silo_regs.sv */
// Register decode, receive silo control and line select of the mux
`timescale 1ns/100ps
`default_nettype none
module four_line_async_mux_silo_regs #(
    // Switch-selected vector; value is arbitrary
    parameter logic [15:0] VECTOR_BASE = 16'h0100
) (
    input wire logic mclk_in,
    input wire logic rst_n_in,
    input wire logic [2:0] bus_addr_in,
    input wire logic [15:0] bus_data_in,
    input wire logic bus_read_in,
    input wire logic bus_write_lo_in,
    input wire logic bus_write_hi_in,
    input wire logic bus_iack_in,
    input wire logic bus_init_in,
    output logic [15:0] bus_data_out,
    output logic bus_data_oe_out,
    output logic bus_reply_out,
    output logic vector_drive_out,
    output logic intr_req_out,
    input wire logic [3:0] data_avail_in,
    input wire mux_pkg::uart_rx_t [3:0] rx_word_in,
    input wire logic [3:0] tx_empty_in,
    input wire logic [7:0] modem_in,
    output logic [3:0] data_avail_reset_out,
    output logic [3:0] holding_load_strobe_n_out,
    output logic [7:0] transmit_char_bit_out,
    output mux_pkg::line_param_t [3:0] line_param_out,
    output logic [3:0] dtr_out,
    output logic [7:0] break_out,
    output logic maint_out
);
    typedef struct packed {
        mux_pkg::pins_t pin_m;
        mux_pkg::pins_t pin_s;
        logic [4:0] strobe_d;
        logic transmit_interrupt_enable;
        logic silo_alarm_enable;
        logic silo_alarm_flag;
        logic rie;
        logic mse;
        logic maint;
        logic clr_req;
        logic [1:0] tline;
        logic [3:0] line_en;
        logic [3:0] dtr;
        logic [7:0] brk;
        logic [7:0] tx_char;
        mux_pkg::line_param_t [3:0] params;
        logic [2:0] scan_cnt;
        logic [1:0] rx_line;
        logic [4:0] alarm_cnt;
        logic tx_wait;
        logic [15:0] rd_data;
        logic data_oe;
        logic reply;
        logic vector_drive;
        logic [3:0] hold_load;
        logic [3:0] da_reset;
    } state_t;

    state_t s;
    state_t next_s;
    mux_pkg::pins_t pins_now;
    mux_pkg::silo_entry_t silo_in;
    mux_pkg::silo_entry_t silo_out;
    logic [4:0] rise;
    logic [2:0] sel;
    logic [15:0] wdata;
    logic tick;
    logic init;
    logic in_ready;
    logic rdone;
    logic silo_load;
    logic receive_buffer_read;
    logic csr_lo_wr;
    logic transmitter_ready_flag;
    logic rx_irq;
    logic tx_irq;

    assign pins_now.addr = bus_addr_in;
    assign pins_now.data = bus_data_in;
    assign pins_now.strobe = {bus_init_in, bus_iack_in, bus_write_hi_in,
                              bus_write_lo_in, bus_read_in};
    assign pins_now.da = data_avail_in;
    assign pins_now.tbmt = tx_empty_in;
    assign pins_now.modem = modem_in;
    assign pins_now.rx = rx_word_in;

    // Address and data are sampled two stages late, like the strobes,
    // so they line up with the strobe edge that uses them
    assign rise = s.pin_s.strobe & ~s.strobe_d;
    assign sel = mux_pkg::reg_addr(s.pin_s.addr);
    assign wdata = s.pin_s.data;
    assign tick = s.mse && (s.scan_cnt == mux_pkg::SCAN_LAST);
    assign init = s.clr_req | s.pin_s.strobe[mux_pkg::ST_INIT];
    assign receive_buffer_read = rise[mux_pkg::ST_RD]
                       && (sel == mux_pkg::ADDR_RECEIVE_BUFFER);
    assign csr_lo_wr = rise[mux_pkg::ST_WLO]
                       && (sel == mux_pkg::ADDR_CONTROL_STATUS);
    // Scanned line is loaded only on a scan tick, which spaces loads
    // past the input synchroniser so one character is not taken twice
    assign silo_load = tick && s.pin_s.da[s.rx_line] && in_ready;
    assign transmitter_ready_flag = s.mse && s.line_en[s.tline]
                  && s.pin_s.tbmt[s.tline] && !s.tx_wait;
    assign rx_irq = s.rie
                    && (s.silo_alarm_enable ? s.silo_alarm_flag : rdone);
    assign tx_irq = s.transmit_interrupt_enable && transmitter_ready_flag;

    assign silo_in.fram = s.pin_s.rx[s.rx_line].fram;
    assign silo_in.ovrn = s.pin_s.rx[s.rx_line].ovrn;
    assign silo_in.par = s.pin_s.rx[s.rx_line].par;
    assign silo_in.line = s.rx_line;
    assign silo_in.data = s.pin_s.rx[s.rx_line].data;

    receive_silo #(
        .DEPTH(mux_pkg::SILO_DEPTH)
    ) u_silo (
        .mclk_in(mclk_in),
        .rst_n_in(rst_n_in),
        .flush_in(init),
        .load_in(silo_load),
        .entry_in(silo_in),
        .unload_in(receive_buffer_read && rdone),
        .in_ready_out(in_ready),
        .out_ready_out(rdone),
        .entry_out(silo_out)
    );

    always_comb
    begin
        next_s = s;
        next_s.pin_m = pins_now;
        next_s.pin_s = s.pin_m;
        next_s.strobe_d = s.pin_s.strobe;
        next_s.hold_load = '0;
        next_s.da_reset = '0;
        next_s.clr_req = 1'b0;
        next_s.scan_cnt = s.scan_cnt + 3'h1;
        next_s.reply = |s.pin_s.strobe[mux_pkg::ST_IAK:mux_pkg::ST_RD];
        next_s.data_oe = s.pin_s.strobe[mux_pkg::ST_RD]
                         | s.pin_s.strobe[mux_pkg::ST_IAK];
        if (!s.pin_s.strobe[mux_pkg::ST_IAK])
            next_s.vector_drive = 1'b0;
        if (rise[mux_pkg::ST_IAK])
        begin
            // Receiver wins when both sources request
            next_s.vector_drive = 1'b1;
            next_s.rd_data = VECTOR_BASE;
            next_s.rd_data[mux_pkg::VEC_SRC_BIT] = !rx_irq;
        end
        if (rise[mux_pkg::ST_RD])
        begin
            next_s.rd_data = '0;
            unique case (sel)
                mux_pkg::ADDR_CONTROL_STATUS:
                begin
                    next_s.rd_data[mux_pkg::CS_TRANSMITTER_READY_FLAG] = transmitter_ready_flag;
                    next_s.rd_data[mux_pkg::CS_TIE] =
                        s.transmit_interrupt_enable;
                    next_s.rd_data[mux_pkg::CS_SA] =
                        s.silo_alarm_flag;
                    next_s.rd_data[mux_pkg::CS_SAE] =
                        s.silo_alarm_enable;
                    next_s.rd_data[mux_pkg::CS_TLINE_LO+:2] =
                        s.tline;
                    next_s.rd_data[mux_pkg::CS_RDONE] = rdone;
                    next_s.rd_data[mux_pkg::CS_RIE] = s.rie;
                    next_s.rd_data[mux_pkg::CS_MSE] = s.mse;
                    next_s.rd_data[mux_pkg::CS_MAINT] = s.maint;
                end
                mux_pkg::ADDR_RECEIVE_BUFFER:
                begin
                    next_s.rd_data[mux_pkg::RB_VALID] = rdone;
                    next_s.rd_data[mux_pkg::RB_OVRN] = silo_out.ovrn;
                    next_s.rd_data[mux_pkg::RB_FRAM] = silo_out.fram;
                    next_s.rd_data[mux_pkg::RB_PAR] = silo_out.par;
                    next_s.rd_data[mux_pkg::RB_LINE_LO+:2] =
                        silo_out.line;
                    next_s.rd_data[7:0] = silo_out.data;
                end
                mux_pkg::ADDR_TRANSMITTER_CONTROL:
                begin
                    next_s.rd_data[mux_pkg::TC_EN_LO+:4] = s.line_en;
                    next_s.rd_data[mux_pkg::TC_DTR_LO+:4] = s.dtr;
                end
                mux_pkg::ADDR_MODEM_STATUS:
                begin
                    next_s.rd_data[mux_pkg::MS_RING_LO+:4] =
                        s.pin_s.modem[3:0];
                    next_s.rd_data[mux_pkg::MS_CARR_LO+:4] = s.pin_s.modem[7:4];
                end
                default:
                begin
                    next_s.rd_data = '0;
                end
            endcase
        end
        // Transmit scanner moves on while the selected line cannot take data
        if (tick && !transmitter_ready_flag)
        begin
            next_s.tline = s.tline + 2'h1;
            next_s.tx_wait = 1'b0;
        end
        if (rise[mux_pkg::ST_WLO])
        begin
            unique case (sel)
                mux_pkg::ADDR_CONTROL_STATUS:
                begin
                    next_s.maint = wdata[mux_pkg::CS_MAINT];
                    next_s.clr_req = wdata[mux_pkg::CS_CLR];
                    next_s.mse = wdata[mux_pkg::CS_MSE];
                    next_s.rie = wdata[mux_pkg::CS_RIE];
                end
                mux_pkg::ADDR_LINE_PARAMETERS:
                begin
                    next_s.params[wdata[mux_pkg::LP_LINE_LO+:2]] = '{
                        receive_line_enable: wdata[mux_pkg::LP_RX_EN],
                        speed: wdata[mux_pkg::LP_SPEED_LO+:4],
                        odd: wdata[mux_pkg::LP_ODD],
                        par_en: wdata[mux_pkg::LP_PAR_EN],
                        stop: wdata[mux_pkg::LP_STOP],
                        len: wdata[mux_pkg::LP_LEN_LO+:2]
                    };
                end
                mux_pkg::ADDR_TRANSMITTER_CONTROL:
                begin
                    next_s.line_en = wdata[mux_pkg::TC_EN_LO+:4];
                end
                mux_pkg::ADDR_TRANSMIT_DATA:
                begin
                    next_s.tx_char = wdata[7:0];
                    if (transmitter_ready_flag)
                    begin
                        next_s.hold_load[s.tline] = 1'b1;
                        next_s.tx_wait = 1'b1;
                    end
                end
                default:
                begin
                    next_s.tx_wait = next_s.tx_wait;
                end
            endcase
        end
        if (rise[mux_pkg::ST_WHI])
        begin
            if (sel == mux_pkg::ADDR_CONTROL_STATUS)
            begin
                next_s.silo_alarm_enable = wdata[mux_pkg::CS_SAE];
                next_s.transmit_interrupt_enable = wdata[mux_pkg::CS_TIE];
            end
            if (sel == mux_pkg::ADDR_TRANSMITTER_CONTROL)
                next_s.dtr = wdata[mux_pkg::TC_DTR_LO+:4];
            if (sel == mux_pkg::ADDR_TRANSMIT_DATA)
                next_s.brk = wdata[mux_pkg::TD_BRK_LO+:8];
        end
        if (tick)
            next_s.rx_line = s.rx_line + 2'h1;
        if (silo_load)
            next_s.da_reset[s.rx_line] = 1'b1;
        // A load in the clearing cycle still counts afterwards
        if (receive_buffer_read)
        begin
            next_s.silo_alarm_flag = 1'b0;
            next_s.alarm_cnt = '0;
        end
        if (silo_load && next_s.alarm_cnt != mux_pkg::ALARM_COUNT)
        begin
            next_s.alarm_cnt = next_s.alarm_cnt + 5'h1;
            if (next_s.alarm_cnt == mux_pkg::ALARM_COUNT)
                next_s.silo_alarm_flag = 1'b1;
        end
        if (!s.silo_alarm_enable)
        begin
            next_s.silo_alarm_flag = 1'b0;
            next_s.alarm_cnt = '0;
        end
        if (init)
        begin
            next_s.transmit_interrupt_enable = 1'b0;
            next_s.silo_alarm_enable = 1'b0;
            next_s.silo_alarm_flag = 1'b0;
            next_s.rie = 1'b0;
            next_s.mse = 1'b0;
            next_s.maint = 1'b0;
            next_s.tline = '0;
            next_s.line_en = '0;
            next_s.dtr = '0;
            next_s.brk = '0;
            next_s.params = '0;
            next_s.alarm_cnt = '0;
            next_s.tx_wait = 1'b0;
        end
    end

    always_ff @(posedge mclk_in)
    begin
        if (!rst_n_in)
            s <= '0;
        else
            s <= next_s;
    end

    assign bus_data_out = s.rd_data;
    assign bus_data_oe_out = s.data_oe;
    assign bus_reply_out = s.reply;
    assign vector_drive_out = s.vector_drive;
    assign intr_req_out = rx_irq | tx_irq;
    assign data_avail_reset_out = s.da_reset;
    assign holding_load_strobe_n_out = ~s.hold_load;
    assign transmit_char_bit_out = s.tx_char;
    assign line_param_out = s.params;
    assign dtr_out = s.dtr;
    assign break_out = s.brk;
    assign maint_out = s.maint;

    default clocking @(posedge mclk_in);
    endclocking
    default disable iff (!rst_n_in);

    a_alarm_at_sixteen: assert property (
        (s.silo_alarm_enable && s.alarm_cnt == 5'h0f && silo_load
         && !receive_buffer_read && !init) |=> s.silo_alarm_flag)
        else $error("silo alarm missed the sixteenth character");
    a_alarm_read_clear: assert property (
        receive_buffer_read |=> !s.silo_alarm_flag)
        else $error("silo alarm survived a receive buffer read");
    a_alarm_needs_enable: assert property (
        !s.silo_alarm_enable |=> !s.silo_alarm_flag)
        else $error("silo alarm set while alarm enable clear");
    a_load_request_cause: assert property (
        silo_load |-> s.pin_s.da[s.rx_line] && in_ready
        ##1 data_avail_reset_out == (4'h1 << $past(s.rx_line)))
        else $error("silo load without data or room");
    a_vector_with_reply: assert property (
        $rose(vector_drive_out) |-> bus_reply_out && bus_data_oe_out)
        else $error("vector driven without bus reply");
    a_vector_source_bit: assert property (
        $rose(vector_drive_out) |-> bus_data_out[2] == !$past(rx_irq))
        else $error("vector bit 2 does not match source");
    a_ready_needs_line: assert property (
        transmitter_ready_flag |-> s.line_en[s.tline] && s.pin_s.tbmt[s.tline])
        else $error("transmitter ready without a ready line");
    a_strobe_to_tline: assert property (
        (s.hold_load != 4'h0) |-> s.hold_load == (4'h1 << $past(s.tline))
        ##1 s.hold_load == 4'h0)
        else $error("holding load strobe on wrong line");
    a_receive_buffer_valid_bit: assert property (
        receive_buffer_read |=> bus_data_out[15] == $past(rdone))
        else $error("receive buffer valid bit wrong");
    a_clear_inits: assert property (
        (csr_lo_wr && wdata[4]) |=> s.clr_req ##1 (!s.mse && !rdone))
        else $error("clear bit did not initialise");
endmodule
`default_nettype wire

/* verif/uart_quad_model.sv */
// Behavioural model of the four line UARTs facing the mux
`timescale 1ns/100ps
`default_nettype none
module uart_quad_model (
    input wire logic mclk_in,
    input wire logic [3:0] push_in,
    input wire logic [7:0] char_in,
    input wire logic [3:0] da_reset_in,
    input wire logic [3:0] load_n_in,
    output logic [3:0] data_avail_out = 4'h0,
    output mux_pkg::uart_rx_t [3:0] rx_word_out = '0,
    output logic [3:0] tx_empty_out = 4'hF
);
    int busy [4] = '{default: 0};
    always @(posedge mclk_in)
        for (int i = 0; i < 4; i++)
        begin
            if (push_in[i])
            begin
                data_avail_out[i] <= 1'b1;
                rx_word_out[i] <= {3'b000, char_in};
            end
            else if (da_reset_in[i])
            begin
                // Released word is inverted so a stale read cannot match
                data_avail_out[i] <= 1'b0;
                rx_word_out[i] <= ~rx_word_out[i];
            end
            if (!load_n_in[i])
            begin
                tx_empty_out[i] <= 1'b0;
                busy[i] <= 6;
            end
            else if (busy[i] > 0)
            begin
                busy[i] <= busy[i] - 1;
                tx_empty_out[i] <= (busy[i] == 1);
            end
        end
endmodule
`default_nettype wire

/* verif/four_line_async_mux_silo_regs_test.sv */
// Self-checking bench for the mux register and silo block
`timescale 1ns/100ps
`default_nettype none
module four_line_async_mux_silo_regs_test;
    logic mclk_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic [2:0] addr = 3'h0;
    logic [15:0] wdata = 16'h0000;
    logic [3:0] stb = 4'h0;
    logic init_pin = 1'b0;
    logic [3:0] push = 4'h0;
    logic [7:0] rx_char = 8'h00;
    logic [15:0] bus_data_out, q;
    logic bus_reply_out, vector_drive_out, intr_req_out, vd;
    logic [3:0] da, da_rst, ld_n, tx_empty, seen_ld = 4'h0;
    logic [7:0] tx_char, seen_ch;
    mux_pkg::uart_rx_t [3:0] rx_word;
    mux_pkg::line_param_t [3:0] lp;
    int err_total = 0;
    int total_checks = 0;
    int cycles = 0;
    int i;
    four_line_async_mux_silo_regs #(.VECTOR_BASE(16'h0200))
        four_line_async_mux_silo_regs_i (
        .mclk_in(mclk_in), .rst_n_in(rst_n_in), .bus_addr_in(addr),
        .bus_data_in(wdata), .bus_read_in(stb[0]),
        .bus_write_lo_in(stb[1]), .bus_write_hi_in(stb[2]),
        .bus_iack_in(stb[3]), .bus_init_in(init_pin),
        .bus_data_out(bus_data_out), .bus_data_oe_out(),
        .bus_reply_out(bus_reply_out), .vector_drive_out(vector_drive_out),
        .intr_req_out(intr_req_out), .data_avail_in(da),
        .rx_word_in(rx_word), .tx_empty_in(tx_empty), .modem_in(8'hA5),
        .data_avail_reset_out(da_rst), .holding_load_strobe_n_out(ld_n),
        .transmit_char_bit_out(tx_char), .line_param_out(lp),
        .dtr_out(), .break_out(), .maint_out());
    uart_quad_model uart_quad_model_i (
        .mclk_in(mclk_in), .push_in(push), .char_in(rx_char),
        .da_reset_in(da_rst), .load_n_in(ld_n), .data_avail_out(da),
        .rx_word_out(rx_word), .tx_empty_out(tx_empty));
    initial
    begin
        forever #12.5 mclk_in = ~mclk_in;
    end
    always @(posedge mclk_in)
        if (ld_n !== 4'hF)
        begin
            seen_ld <= ~ld_n;
            seen_ch <= tx_char;
        end
    task automatic wrap_up;
        if (err_total == 0 && total_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    always @(posedge mclk_in)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            err_total++;
            wrap_up();
        end
    end
    task automatic chk(input string what, input logic [15:0] seen, exp);
        total_checks++;
        if (seen !== exp)
        begin
            err_total++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // Strobe bits: iack, write high, write low, read
    task automatic cyc(input logic [2:0] a, input logic [15:0] d,
        input logic [3:0] s);
        int n;
        @(posedge mclk_in);
        addr <= a;
        wdata <= d;
        stb <= s;
        for (n = 0; n < 20 && bus_reply_out !== 1'b1; n++)
            @(posedge mclk_in);
        q = bus_data_out;
        vd = vector_drive_out;
        stb <= 4'h0;
        if (n == 20)
            err_total++;
        for (n = 0; n < 20 && bus_reply_out !== 1'b0; n++)
            @(posedge mclk_in);
    endtask
    task automatic put(input logic [7:0] c);
        int n;
        @(posedge mclk_in);
        push <= 4'h2;
        rx_char <= c;
        @(posedge mclk_in);
        push <= 4'h0;
        @(posedge mclk_in);
        for (n = 0; n < 100 && da[1] !== 1'b0; n++)
            @(posedge mclk_in);
        if (n == 100)
            err_total++;
    endtask
    initial
    begin
        repeat (20) @(posedge mclk_in);
        rst_n_in <= 1'b1;
        cyc(3'h0, 16'h0000, 4'h1);
        chk("control_status", q, 16'h0000);
        cyc(3'h2, 16'h1A21, 4'h2);
        chk("line 1 params", 16'(lp[1]), 16'h0344);
        chk("line 0 params", 16'(lp[0]), 16'h0000);
        cyc(3'h0, 16'h1020, 4'h6);
        cyc(3'h4, 16'h0002, 4'h2);
        cyc(3'h4, 16'h0000, 4'h1);
        chk("transmitter_control", q, 16'h0002);
        for (i = 0; i < 16; i++)
            put(8'(8'h40 + i));
        cyc(3'h0, 16'h0000, 4'h1);
        chk("alarm bits", {14'h0, q[13:12]}, 16'h0003);
        cyc(3'h2, 16'h0000, 4'h1);
        chk("first char", q, 16'h8140);
        cyc(3'h0, 16'h0000, 4'h1);
        chk("alarm after read", q[13], 1'b0);
        for (i = 1; i < 16; i++)
        begin
            cyc(3'h2, 16'h0000, 4'h1);
            chk("silo order", q, 16'(16'h8140 + i));
        end
        cyc(3'h2, 16'h0000, 4'h1);
        chk("empty silo", q[15], 1'b0);
        for (i = 0; i < 20 && q[15] !== 1'b1; i++)
            cyc(3'h0, 16'h0000, 4'h1);
        chk("transmit line", q[9:8], 2'h1);
        cyc(3'h6, 16'h005A, 4'h2);
        chk("load strobes", seen_ld, 4'h2);
        chk("transmit char", seen_ch, 8'h5A);
        cyc(3'h6, 16'h0000, 4'h1);
        chk("modem_status", q, 16'h0A05);
        cyc(3'h0, 16'h4020, 4'h6);
        for (i = 0; i < 100 && intr_req_out !== 1'b1; i++)
            @(posedge mclk_in);
        cyc(3'h0, 16'h0000, 4'h8);
        chk("tx vector", q, 16'h0204);
        chk("vector drive", vd, 1'b1);
        put(8'h33);
        cyc(3'h0, 16'h0060, 4'h6);
        cyc(3'h0, 16'h0000, 4'h8);
        chk("rx vector", q, 16'h0200);
        cyc(3'h0, 16'h0010, 4'h2);
        cyc(3'h0, 16'h0000, 4'h1);
        chk("cleared control", q, 16'h0000);
        chk("cleared params", 16'(lp[1]), 16'h0000);
        // Bus initialize pin must act like the clear bit
        cyc(3'h0, 16'h1060, 4'h6);
        cyc(3'h0, 16'h0000, 4'h1);
        chk("set control", q & 16'h10F0, 16'h1060);
        @(posedge mclk_in);
        init_pin <= 1'b1;
        repeat (4) @(posedge mclk_in);
        init_pin <= 1'b0;
        repeat (4) @(posedge mclk_in);
        cyc(3'h0, 16'h0000, 4'h1);
        chk("init control", q, 16'h0000);
        wrap_up();
    end
endmodule
`default_nettype wire
